// [hw/acp_consts.svh]
// Constants for the alarm and control pin block
`ifndef ACP_CONSTS_SVH
`define ACP_CONSTS_SVH

`define ACP_CLK_HZ 50000000
`define ACP_CYC_PER_MS (`ACP_CLK_HZ / 1000)
`define ACP_COOLER_EN_MAX_MS 100
`define ACP_COOLER_EN_MAX_CYC (`ACP_CYC_PER_MS * `ACP_COOLER_EN_MAX_MS)
`define ACP_TX_ON_MAX_MS 20
`define ACP_TX_ON_MAX_CYC (`ACP_CYC_PER_MS * `ACP_TX_ON_MAX_MS)
`define ACP_SRQ_MAX_MS 150
`define ACP_SRQ_MAX_CYC (`ACP_CYC_PER_MS * `ACP_SRQ_MAX_MS)
`define ACP_BOOT_MS 1
`define ACP_BOOT_CYC (`ACP_CYC_PER_MS * `ACP_BOOT_MS)
`define ACP_INIT_LATCH_LOC 16'hb022
`define ACP_INIT_LATCH_BIT 0
`define ACP_PM_SYNC_LOC 16'hc02e
`define ACP_PM_SYNC_BIT 15
`define ACP_INIT_LATCH_RST 1'b1
`define ACP_PM_SYNC_RST 1'b0
`define ACP_COOLER_EN_RST 1'b0

`endif

// [hw/acp_pkg.sv]
// Types shared by the alarm and control pin block
package acp_pkg;

  typedef enum logic [2:0] {
    ACP_ST_HOLD = 3'b001,
    ACP_ST_BOOT = 3'b010,
    ACP_ST_RUN = 3'b100
  } acp_ctl_state_t;

  typedef struct packed {
    acp_ctl_state_t st;
    logic [31:0] boot_cnt;
    logic cooler_en;
    logic tx_on;
    logic tx_turn_on;
    logic los_n;
    logic srq_n;
    logic ready_ind;
    logic twi_ok;
    logic twi_en;
    logic init_latch;
    logic pm_sync;
    logic tick_prev;
  } acp_ctl_t;

endpackage

// [hw/acp_pid_if.sv]
// Carrier between the top and one cooler demand channel
`timescale 1ns/1ps
interface acp_pid_if #(
  parameter int DW = 12
);
  logic run;
  logic [DW-1:0] setpoint;
  logic [DW-1:0] measure;
  logic [DW-1:0] demand;

  modport ctl (output run, output setpoint, output measure, input demand);
  modport loop (input run, input setpoint, input measure, output demand);
endinterface

// [hw/acp_sync.sv]
// Two-stage synchroniser for host control pins
`timescale 1ns/1ps
module acp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } acp_sync_st_t;

  acp_sync_st_t st_r;
  acp_sync_st_t st_nxt;

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule

// [hw/acp_pid.sv]
// One closed-loop cooler demand channel
`timescale 1ns/1ps
module acp_pid #(
  parameter int DW = 12,
  parameter int KP_SH = 2,
  parameter int KI_SH = 6,
  parameter int KD_SH = 3
) (
  input wire logic clk,
  input wire logic rst,
  acp_pid_if.loop pl
);
  localparam int AW = DW + 10;
  localparam logic signed [AW-1:0] MID = AW'(1 << (DW - 1));
  localparam logic signed [AW-1:0] TOP = AW'((1 << DW) - 1);

  typedef struct packed {
    logic signed [AW-1:0] integ;
    logic signed [AW-1:0] err_prev;
    logic [DW-1:0] demand;
  } acp_pid_st_t;

  acp_pid_st_t st_r;
  acp_pid_st_t st_nxt;
  logic signed [AW-1:0] err;
  logic signed [AW-1:0] u;
  logic signed [AW-1:0] sum;

  // Low code is full cooling, top code full heating, mid is neutral
  always_comb begin
    st_nxt = st_r;
    err = AW'($signed({1'b0, pl.setpoint}) - $signed({1'b0, pl.measure}));
    u = (err <<< KP_SH) + (st_r.integ >>> KI_SH)
      + ((err - st_r.err_prev) <<< KD_SH);
    sum = MID + u;
    if (!pl.run) begin
      st_nxt.integ = '0;
      st_nxt.err_prev = '0;
      st_nxt.demand = MID[DW-1:0];
    end else begin
      st_nxt.err_prev = err;
      // Integrate only away from a saturated rail to stop windup
      if (sum > TOP) begin
        st_nxt.demand = TOP[DW-1:0];
        if (err < 0) begin
          st_nxt.integ = st_r.integ + err;
        end
      end else if (sum < 0) begin
        st_nxt.demand = '0;
        if (err > 0) begin
          st_nxt.integ = st_r.integ + err;
        end
      end else begin
        st_nxt.demand = sum[DW-1:0];
        st_nxt.integ = st_r.integ + err;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{integ: '0, err_prev: '0, demand: MID[DW-1:0]};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pl.demand = st_r.demand;

  AST_PID_IDLE_MID: assert property (@(posedge clk) disable iff (rst)
    !pl.run |=> pl.demand == MID[DW-1:0])
    else $error("idle cooler demand not at neutral level");
endmodule

// [hw/acp_top.sv]
// Alarm and control pin logic of the optical sub-assembly
//
// How it works
// - Cooler enable output is active high
// - Cooler enable low until controller ready
// - Host reset restarts controller and management only
// - Hold in reset while host reset low
// - Leaving reset restores every setting default
// - Each reset sets the initialize-state latch
// - Demand: low cools, top heats, mid neutral
// - ZONES PID demand channels, three by default
// - Transmit disable low stops light output
// - Transmitter stays off during power-up, reset
// - Loss-of-signal low below programmed power threshold
// - Service request low while fault present in run state
// - Deselected module ignores two-wire traffic
// - No two-wire answers until ready signalled
// - Only the selected module answers
// - Host may set soft interval sync bit
// - Hardware tick may drive sync bit
// - Cooler pin follows control bit promptly
// - Transmitter turn-on after disable release
// - Service request asserts promptly on fault
// - Service request releases promptly after clear
`timescale 1ns/1ps
`include "acp_consts.svh"
module acp_top #(
  parameter int ZONES = 3,
  parameter int DW = 12,
  parameter int PW = 16,
  parameter int FW = 8,
  parameter int unsigned BOOT_CYCLES = `ACP_BOOT_CYC
) (
  // Clock and internal reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // Host control pins
  input wire logic HOST_RESET_N,
  input wire logic TRANSMIT_DISABLE_N,
  input wire logic MODULE_SELECT_N,
  // Controller settings and status sources
  input wire logic COOLER_EN_CTRL,
  input wire logic [PW-1:0] RX_POWER,
  input wire logic [PW-1:0] RECEIVE_SIGNAL_LOST_N_THRESH,
  input wire logic [FW-1:0] FAULT_ALARM_WARNING_STATUS,
  input wire logic INIT_LATCH_CLR,
  // Soft interval sync bit access and hardware tick
  input wire logic PM_SYNC_WR,
  input wire logic PM_SYNC_WDATA,
  input wire logic TICK_MAP_EN,
  input wire logic MONITOR_INTERVAL_TICK,
  // Cooler zones
  input wire logic [ZONES-1:0][DW-1:0] ZONE_SETPOINT,
  input wire logic [ZONES-1:0][DW-1:0] ZONE_TEMP,
  output logic [ZONES-1:0][DW-1:0] COOLER_DEMAND_LEVEL,
  output logic COOLER_ENABLE_OUT,
  // Transmitter control
  output logic TX_LIGHT_ON,
  output logic TX_TURN_ON,
  // Alarm pins
  output logic RECEIVE_SIGNAL_LOST_N,
  output logic SERVICE_REQUEST_N,
  // Management interface status
  output logic TWI_RESPONSE_EN,
  output logic INIT_STATE_LATCH,
  output logic PM_SYNC_BIT
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic host_rst_q;
  logic txdis_q;
  logic modsel_q;

  // Reset values pick the safe side: held, dark, deselected
  acp_sync #(.W(1), .RST_VAL(1'b0)) u_sync_rst (
    .clk(REF_CLK),
    .rst(RESET),
    .d(HOST_RESET_N),
    .q(host_rst_q)
  );

  acp_sync #(.W(1), .RST_VAL(1'b0)) u_sync_txdis (
    .clk(REF_CLK),
    .rst(RESET),
    .d(TRANSMIT_DISABLE_N),
    .q(txdis_q)
  );

  acp_sync #(.W(1), .RST_VAL(1'b1)) u_sync_modsel (
    .clk(REF_CLK),
    .rst(RESET),
    .d(MODULE_SELECT_N),
    .q(modsel_q)
  );

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  localparam acp_pkg::acp_ctl_t RST_ST = '{
    st: acp_pkg::ACP_ST_HOLD,
    boot_cnt: 32'h0,
    cooler_en: `ACP_COOLER_EN_RST,
    tx_on: 1'b0,
    tx_turn_on: 1'b0,
    los_n: 1'b1,
    srq_n: 1'b1,
    ready_ind: 1'b0,
    twi_ok: 1'b0,
    twi_en: 1'b0,
    init_latch: `ACP_INIT_LATCH_RST,
    pm_sync: `ACP_PM_SYNC_RST,
    tick_prev: 1'b0
  };

  acp_pkg::acp_ctl_t st_r;
  acp_pkg::acp_ctl_t st_nxt;
  logic rx_below;
  logic any_fault;
  logic tick_rise;

  always_comb begin
    rx_below = RX_POWER < RECEIVE_SIGNAL_LOST_N_THRESH;
    any_fault = |FAULT_ALARM_WARNING_STATUS;
    tick_rise = MONITOR_INTERVAL_TICK && !st_r.tick_prev;
    st_nxt = st_r;
    st_nxt.tx_turn_on = 1'b0;
    if (!host_rst_q) begin
      // Host reset restores defaults and sets the latch
      st_nxt = RST_ST;
    end else begin
      case (st_r.st)
        acp_pkg::ACP_ST_HOLD: begin
          st_nxt.st = acp_pkg::ACP_ST_BOOT;
          st_nxt.boot_cnt = 32'h0;
        end
        acp_pkg::ACP_ST_BOOT: begin
          st_nxt.cooler_en = 1'b0;
          st_nxt.tx_on = 1'b0;
          if (st_r.boot_cnt >= 32'(BOOT_CYCLES - 1)) begin
            st_nxt.st = acp_pkg::ACP_ST_RUN;
            // Ready is shown by pulling service request low
            st_nxt.ready_ind = 1'b1;
            st_nxt.twi_ok = 1'b1;
          end else begin
            st_nxt.boot_cnt = st_r.boot_cnt + 32'h1;
          end
        end
        acp_pkg::ACP_ST_RUN: begin
          st_nxt.cooler_en = COOLER_EN_CTRL;
          st_nxt.tx_on = txdis_q;
          st_nxt.tx_turn_on = txdis_q && !st_r.tx_on;
          if (PM_SYNC_WR) begin
            st_nxt.pm_sync = PM_SYNC_WDATA;
          end
          // A tick beats a host write in the same cycle
          if (TICK_MAP_EN && tick_rise) begin
            st_nxt.pm_sync = 1'b1;
          end
        end
        default: begin
          st_nxt = RST_ST;
        end
      endcase
      // Clearing the latch also ends the ready indication
      if (INIT_LATCH_CLR && st_r.st != acp_pkg::ACP_ST_HOLD) begin
        st_nxt.init_latch = 1'b0;
        st_nxt.ready_ind = 1'b0;
      end
      if (st_nxt.st == acp_pkg::ACP_ST_BOOT
          && st_r.st == acp_pkg::ACP_ST_BOOT
          && st_nxt.boot_cnt == 32'h0) begin
        st_nxt.init_latch = 1'b1;
      end
    end
    // Loss-of-signal is not part of the controller reset
    st_nxt.los_n = !rx_below;
    st_nxt.tick_prev = MONITOR_INTERVAL_TICK;
    st_nxt.srq_n = (st_nxt.st == acp_pkg::ACP_ST_RUN)
      ? !(any_fault || st_nxt.ready_ind) : 1'b1;
    st_nxt.twi_en = st_nxt.twi_ok && !modsel_q;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      st_r <= RST_ST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Cooler demand channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < ZONES; g++) begin : g_zone
    acp_pid_if #(.DW(DW)) pif ();

    // Loops idle at neutral while the coolers are disabled
    assign pif.run = st_r.cooler_en;
    assign pif.setpoint = ZONE_SETPOINT[g];
    assign pif.measure = ZONE_TEMP[g];
    assign COOLER_DEMAND_LEVEL[g] = pif.demand;

    acp_pid #(.DW(DW)) u_pid (
      .clk(REF_CLK),
      .rst(RESET),
      .pl(pif)
    );
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign COOLER_ENABLE_OUT = st_r.cooler_en;
  assign TX_LIGHT_ON = st_r.tx_on;
  assign TX_TURN_ON = st_r.tx_turn_on;
  assign RECEIVE_SIGNAL_LOST_N = st_r.los_n;
  assign SERVICE_REQUEST_N = st_r.srq_n;
  assign TWI_RESPONSE_EN = st_r.twi_en;
  assign INIT_STATE_LATCH = st_r.init_latch;
  assign PM_SYNC_BIT = st_r.pm_sync;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_COOLER_HELD_LOW: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    !HOST_RESET_N [*4] |-> !COOLER_ENABLE_OUT)
    else $error("cooler enabled while host reset held");

  AST_COOLER_FOLLOWS: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (st_r.st == acp_pkg::ACP_ST_RUN && host_rst_q)
      |=> COOLER_ENABLE_OUT == $past(COOLER_EN_CTRL))
    else $error("cooler pin did not follow control bit");

  AST_BOOT_WAITS: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    !HOST_RESET_N [*4] |-> st_r.st == acp_pkg::ACP_ST_HOLD)
    else $error("left reset mode while host reset low");

  AST_DEFAULTS: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    $rose(st_r.st == acp_pkg::ACP_ST_BOOT)
      |-> !PM_SYNC_BIT && !COOLER_ENABLE_OUT && !TX_LIGHT_ON)
    else $error("setting not at default after reset");

  AST_INIT_LATCH: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    st_r.st == acp_pkg::ACP_ST_HOLD |=> INIT_STATE_LATCH)
    else $error("reset event not latched");

  AST_TX_OFF: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    !TRANSMIT_DISABLE_N [*4] |-> !TX_LIGHT_ON)
    else $error("light on while transmit disable low");

  AST_TX_TURN_ON: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    $rose(TX_LIGHT_ON) |-> TX_TURN_ON ##1 !TX_TURN_ON)
    else $error("turn-on pulse missing or too long");

  AST_LOS_LOW: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (RX_POWER < RECEIVE_SIGNAL_LOST_N_THRESH) |=> !RECEIVE_SIGNAL_LOST_N)
    else $error("loss of signal not flagged below threshold");

  AST_SRQ_FAULT: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (st_r.st == acp_pkg::ACP_ST_RUN && host_rst_q
      && |FAULT_ALARM_WARNING_STATUS) |=> !SERVICE_REQUEST_N)
    else $error("service request not raised on fault");

  AST_SRQ_CLEAR: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (st_r.st == acp_pkg::ACP_ST_RUN && !st_r.ready_ind
      && !INIT_LATCH_CLR && host_rst_q
      && !(|FAULT_ALARM_WARNING_STATUS)) ##1
      (!(|FAULT_ALARM_WARNING_STATUS) && host_rst_q)
      |-> SERVICE_REQUEST_N)
    else $error("service request held with no fault");

  AST_TWI_DESELECT: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    MODULE_SELECT_N [*4] |-> !TWI_RESPONSE_EN)
    else $error("two-wire answer while deselected");

  AST_TWI_NOT_READY: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    st_r.st != acp_pkg::ACP_ST_RUN |-> !TWI_RESPONSE_EN)
    else $error("two-wire answer before ready");

  AST_PM_SET: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (st_r.st == acp_pkg::ACP_ST_RUN && host_rst_q && PM_SYNC_WR
      && PM_SYNC_WDATA) |=> PM_SYNC_BIT)
    else $error("soft interval sync bit not set");

  AST_PM_TICK: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (st_r.st == acp_pkg::ACP_ST_RUN && host_rst_q && TICK_MAP_EN
      && $rose(MONITOR_INTERVAL_TICK)) |=> PM_SYNC_BIT)
    else $error("hardware tick lost");

  AST_LOS_HIGH: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (RX_POWER >= RECEIVE_SIGNAL_LOST_N_THRESH) |=> RECEIVE_SIGNAL_LOST_N)
    else $error("loss of signal flagged above threshold");

  AST_TX_DARK_NOT_RUN: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    st_r.st != acp_pkg::ACP_ST_RUN |-> !TX_LIGHT_ON && !TX_TURN_ON)
    else $error("transmitter on outside run");

  AST_COOLER_NOT_RUN: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    st_r.st != acp_pkg::ACP_ST_RUN |-> !COOLER_ENABLE_OUT)
    else $error("cooler enabled before controller ready");

  AST_SRQ_NOT_RUN: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    st_r.st != acp_pkg::ACP_ST_RUN |-> SERVICE_REQUEST_N)
    else $error("service request low before ready");

  AST_PM_REFUSED: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    st_r.st != acp_pkg::ACP_ST_RUN |-> !PM_SYNC_BIT)
    else $error("sync bit set outside run");

  AST_TWI_SELECTED: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (st_r.st == acp_pkg::ACP_ST_RUN && host_rst_q && !modsel_q)
      |=> TWI_RESPONSE_EN)
    else $error("selected module does not answer");

  AST_READY_SHOWN: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    ($rose(st_r.st == acp_pkg::ACP_ST_RUN) && !$past(INIT_LATCH_CLR))
      |-> !SERVICE_REQUEST_N)
    else $error("ready not shown on service request");

  AST_TURN_ON_LIGHT: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    TX_TURN_ON |-> TX_LIGHT_ON)
    else $error("turn-on pulse without light enabled");
endmodule

// [verif/acp_host_model.sv]
// Host controller model driving the module's control pins
`timescale 1ns/1ps
module acp_host_model (
  // Host control pins
  output logic host_reset_n,
  output logic transmit_disable_n_n,
  output logic module_select_n_n
);
  // ------------------------------------------------------------
  // Pin levels
  // ------------------------------------------------------------
  // Power-up levels follow the pull resistors on each line
  initial begin
    host_reset_n = 1'b0;
    transmit_disable_n_n = 1'b0;
    module_select_n_n = 1'b1;
  end

  // Booting starts only once the host lets go of reset
  task automatic set_reset(input logic v);
    host_reset_n = v;
  endtask

  // Module is powered before the laser may be turned on
  task automatic set_tx(input logic v);
    transmit_disable_n_n = v;
  endtask

  // Select moves only between transfers, one module at a time
  task automatic set_sel(input logic v);
    module_select_n_n = v;
  endtask
endmodule

// [verif/module_alarm_control_pins_bench.sv]
// Self-checking bench for the alarm and control pin block
`timescale 1ns/1ps
module module_alarm_control_pins_bench;
  logic ref_clk = 1'b0;
  logic reset;
  logic host_reset_n, transmit_disable_n_n, module_select_n_n;
  logic cooler_en_ctrl, init_latch_clr, pm_sync_wr, pm_sync_wdata;
  logic tick_map_en, tick;
  logic [15:0] rx_power, receive_signal_lost_n_thresh;
  logic [7:0] fault_alarm_warning_status;
  logic [2:0][11:0] zone_setpoint, zone_temp;
  logic [2:0][11:0] demand;
  logic cooler_out, light_on, turn_on, los_n, srq_n;
  logic twi_en, init_latch, pm_bit;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int i;

  always #10 ref_clk = ~ref_clk;

  acp_host_model u_acp_host_model (
    .host_reset_n(host_reset_n),
    .transmit_disable_n_n(transmit_disable_n_n),
    .module_select_n_n(module_select_n_n)
  );

  acp_top #(.BOOT_CYCLES(4)) u_acp_top (
    .REF_CLK(ref_clk), .RESET(reset),
    .HOST_RESET_N(host_reset_n), .TRANSMIT_DISABLE_N(transmit_disable_n_n),
    .MODULE_SELECT_N(module_select_n_n), .COOLER_EN_CTRL(cooler_en_ctrl),
    .RX_POWER(rx_power), .RECEIVE_SIGNAL_LOST_N_THRESH(receive_signal_lost_n_thresh),
    .FAULT_ALARM_WARNING_STATUS(fault_alarm_warning_status), .INIT_LATCH_CLR(init_latch_clr),
    .PM_SYNC_WR(pm_sync_wr), .PM_SYNC_WDATA(pm_sync_wdata),
    .TICK_MAP_EN(tick_map_en), .MONITOR_INTERVAL_TICK(tick),
    .ZONE_SETPOINT(zone_setpoint), .ZONE_TEMP(zone_temp),
    .COOLER_DEMAND_LEVEL(demand), .COOLER_ENABLE_OUT(cooler_out),
    .TX_LIGHT_ON(light_on), .TX_TURN_ON(turn_on),
    .RECEIVE_SIGNAL_LOST_N(los_n), .SERVICE_REQUEST_N(srq_n),
    .TWI_RESPONSE_EN(twi_en), .INIT_STATE_LATCH(init_latch),
    .PM_SYNC_BIT(pm_bit)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Inputs change and outputs are read 1 ns after the edge
  task automatic tick_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (srq_n !== 1'b0 && n < 50) begin
      tick_n(1);
      n++;
    end
  endtask

  task automatic finish_test();
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run is under two hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= 3000) begin
      errors++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    cooler_en_ctrl = 1'b0;
    init_latch_clr = 1'b0;
    pm_sync_wr = 1'b0;
    pm_sync_wdata = 1'b0;
    tick_map_en = 1'b0;
    tick = 1'b0;
    rx_power = 16'h0100;
    receive_signal_lost_n_thresh = 16'h0080;
    fault_alarm_warning_status = 8'h00;
    zone_setpoint = '0;
    zone_temp = '0;
    tick_n(3);
    reset = 1'b0;
    chk("cooler_rst", 16'h0, {15'h0, cooler_out});
    chk("light_rst", 16'h0, {15'h0, light_on});
    chk("latch_rst", 16'h1, {15'h0, init_latch});
    chk("pm_rst", 16'h0, {15'h0, pm_bit});
    chk("demand_rst", 16'h0800, {4'h0, demand[0]});
    tick_n(20);
    chk("srq_hold", 16'h1, {15'h0, srq_n});
    chk("twi_hold", 16'h0, {15'h0, twi_en});
    u_acp_host_model.set_reset(1'b1);
    wait_ready();
    chk("srq_ready", 16'h0, {15'h0, srq_n});
    chk("twi_unsel", 16'h0, {15'h0, twi_en});
    // Zone 0 heats, zone 1 cools, zone 2 sits at balance
    zone_setpoint[0] = 12'hfff;
    zone_temp[1] = 12'hfff;
    cooler_en_ctrl = 1'b1;
    tick_n(1);
    chk("cooler_on", 16'h1, {15'h0, cooler_out});
    tick_n(60);
    chk("demand_heat", 16'h1, {15'h0, demand[0] > 12'h800});
    chk("demand_cool", 16'h1, {15'h0, demand[1] < 12'h800});
    chk("demand_mid", 16'h0800, {4'h0, demand[2]});
    cooler_en_ctrl = 1'b0;
    tick_n(1);
    chk("cooler_off", 16'h0, {15'h0, cooler_out});
    tick_n(2);
    chk("demand_idle", 16'h0800, {4'h0, demand[0]});
    u_acp_host_model.set_tx(1'b1);
    tick_n(2);
    chk("light_sync", 16'h0, {15'h0, light_on});
    tick_n(1);
    chk("light_on", 16'h1, {15'h0, light_on});
    chk("turn_on", 16'h1, {15'h0, turn_on});
    tick_n(1);
    chk("turn_on_end", 16'h0, {15'h0, turn_on});
    u_acp_host_model.set_tx(1'b0);
    tick_n(3);
    chk("light_off", 16'h0, {15'h0, light_on});
    u_acp_host_model.set_sel(1'b0);
    tick_n(3);
    chk("twi_sel", 16'h1, {15'h0, twi_en});
    u_acp_host_model.set_sel(1'b1);
    tick_n(3);
    chk("twi_desel", 16'h0, {15'h0, twi_en});
    rx_power = 16'h0080;
    tick_n(1);
    chk("los_equal", 16'h1, {15'h0, los_n});
    rx_power = 16'h007f;
    tick_n(1);
    chk("los_below", 16'h0, {15'h0, los_n});
    rx_power = 16'h0100;
    receive_signal_lost_n_thresh = 16'h0101;
    tick_n(1);
    chk("los_thresh", 16'h0, {15'h0, los_n});
    receive_signal_lost_n_thresh = 16'h0080;
    init_latch_clr = 1'b1;
    tick_n(1);
    init_latch_clr = 1'b0;
    chk("los_above", 16'h1, {15'h0, los_n});
    chk("srq_clear", 16'h1, {15'h0, srq_n});
    chk("latch_clear", 16'h0, {15'h0, init_latch});
    for (i = 0; i < 8; i++) begin
      fault_alarm_warning_status = 8'h01 << i;
      tick_n(1);
      chk("srq_fault", 16'h0, {15'h0, srq_n});
      fault_alarm_warning_status = 8'h00;
      tick_n(1);
      chk("srq_release", 16'h1, {15'h0, srq_n});
    end
    pm_sync_wr = 1'b1;
    pm_sync_wdata = 1'b1;
    tick_n(1);
    chk("pm_set", 16'h1, {15'h0, pm_bit});
    pm_sync_wdata = 1'b0;
    tick_n(1);
    pm_sync_wr = 1'b0;
    chk("pm_clr", 16'h0, {15'h0, pm_bit});
    tick = 1'b1;
    tick_n(2);
    chk("pm_unmapped", 16'h0, {15'h0, pm_bit});
    tick = 1'b0;
    tick_n(1);
    // Tick set beats a write of zero in the same cycle
    tick_map_en = 1'b1;
    tick = 1'b1;
    pm_sync_wr = 1'b1;
    tick_n(1);
    pm_sync_wr = 1'b0;
    chk("pm_tick", 16'h1, {15'h0, pm_bit});
    tick = 1'b0;
    // Host reset in mid-run: controller side returns to defaults
    cooler_en_ctrl = 1'b1;
    u_acp_host_model.set_tx(1'b1);
    tick_n(4);
    u_acp_host_model.set_reset(1'b0);
    tick_n(4);
    chk("cooler_hrst", 16'h0, {15'h0, cooler_out});
    chk("light_hrst", 16'h0, {15'h0, light_on});
    chk("pm_hrst", 16'h0, {15'h0, pm_bit});
    chk("latch_hrst", 16'h1, {15'h0, init_latch});
    chk("srq_hrst", 16'h1, {15'h0, srq_n});
    rx_power = 16'h0010;
    pm_sync_wr = 1'b1;
    pm_sync_wdata = 1'b1;
    init_latch_clr = 1'b1;
    tick_n(1);
    pm_sync_wr = 1'b0;
    init_latch_clr = 1'b0;
    chk("los_hrst", 16'h0, {15'h0, los_n});
    chk("pm_refused", 16'h0, {15'h0, pm_bit});
    chk("latch_held", 16'h1, {15'h0, init_latch});
    finish_test();
  end
endmodule
